// [rtl/cdsl_loader.sv]
// Purpose: serial loader for the two reference level codes
// Assumes: serial pins asynchronous to hclk; link clock far below
//          hclk so every serial edge is seen after synchronising
// Notes: levels change only when the load enable returns high after
//        a full word; output mode is software's unless test forces it
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cdsl_defines.svh"

// Notes on behaviour
// (RL1) A falling load enable starts a new loading cycle.
// (RL2) While the enable is low each serial clock rise adds one bit, up to a 12-bit word.
// (RL3) The first bit picks the output, the next three are unused, the last eight are the code.
// (RL4) A level changes only at the rising load enable, never at any other time.
// (RL5) While the enable is high, serial clock and data are ignored.
// (RL6) With test mode low the output mode follows the programmed function.
// (RL7) With test mode high the output mode is forced to normal.
// (RL8) Select 0 means output a, 1 means output b, and the code arrives msb first.
module cdsl_loader (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    ce,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic                    ref_dac_serial_clk,
    input  wire logic                    ref_dac_serial_in,
    input  wire logic                    ref_dac_load_enable_n,
    input  wire logic                    test_mode_force,
    output logic      [`CDSL_CODE_W-1:0] ref_level_out_a,
    output logic      [`CDSL_CODE_W-1:0] ref_level_out_b,
    output logic      [`CDSL_MODE_W-1:0] output_mode
);
    cdsl_pkg::cdsl_core_type r;
    cdsl_pkg::cdsl_core_type r_nxt;
    logic                    word_full;
    logic                    busy;

    cdsl_core_if cif ();

    cdsl_pin_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pins    ({test_mode_force, ref_dac_load_enable_n,
                   ref_dac_serial_in, ref_dac_serial_clk}),
        .ev      (cif.sync)
    );

    cdsl_ahb_regs u_regs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rif       (cif.regs)
    );

    // select bit decode, shared by the load path and its checks
    function automatic logic sel_is_b(input logic [`CDSL_WORD_W-1:0] w);
        return w[`CDSL_SEL_BIT];
    endfunction : sel_is_b

    assign word_full = (r.cnt == `CDSL_WORD_BITS);
    assign busy      = (r.state == cdsl_pkg::CDSL_SHIFT);

    always_comb begin
        r_nxt = r;
        if (ce) begin
            case (r.state)
                cdsl_pkg::CDSL_IDLE: begin
                    // (RL1) frame start
                    if (cif.en_fall) begin
                        r_nxt.state = cdsl_pkg::CDSL_SHIFT;
                        r_nxt.cnt   = `CDSL_CNT_RST;
                        r_nxt.word  = `CDSL_WORD_RST;
                    end
                    // (RL5) idle ignores serial clock
                end
                cdsl_pkg::CDSL_SHIFT: begin
                    if (cif.en_rise) begin
                        r_nxt.state = cdsl_pkg::CDSL_IDLE;
                        // (RL4) update at enable rise
                        if (word_full) begin
                            // (RL3) positional word fields
                            // (RL8) select bit decode
                            if (sel_is_b(r.word)) begin
                                r_nxt.lvl_b = r.word[`CDSL_CODE_MSB:0];
                            end else begin
                                r_nxt.lvl_a = r.word[`CDSL_CODE_MSB:0];
                            end
                            r_nxt.short_frame = 1'b0;
                            r_nxt.frames      = `CDSL_CODE_W'(r.frames + 1'b1);
                        end else begin
                            // a short word is dropped, levels hold
                            r_nxt.short_frame = 1'b1;
                        end
                    end else if (cif.sclk_rise && !word_full) begin
                        // (RL2) one bit per clock rise
                        // (RL8) msb first shift
                        r_nxt.word = {r.word[`CDSL_WORD_W-2:0], cif.sdata};
                        r_nxt.cnt  = `CDSL_CNT_W'(r.cnt + 1'b1);
                    end
                end
                default: begin
                    r_nxt.state = cdsl_pkg::CDSL_IDLE;
                end
            endcase
            // (RL7) test forces normal
            // (RL6) otherwise programmed mode
            r_nxt.mode = cif.tmode ? `CDSL_MODE_NORMAL : cif.mode_prog;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{state: cdsl_pkg::CDSL_IDLE, cnt: `CDSL_CNT_RST,
                   word: `CDSL_WORD_RST, lvl_a: `CDSL_LEVEL_RST,
                   lvl_b: `CDSL_LEVEL_RST, mode: `CDSL_MODE_RST,
                   short_frame: 1'b0, frames: `CDSL_FRAMES_RST};
        end else begin
            r <= r_nxt;
        end
    end

    // status: busy, bit count, short word, test level, mode, frames
    assign cif.status = {8'h00,
                         r.frames,
                         6'h00,
                         r.mode,
                         1'b0,
                         cif.tmode,
                         r.short_frame,
                         r.cnt,
                         busy};
    assign cif.levels = {16'h0000, r.lvl_b, r.lvl_a};

    assign ref_level_out_a = r.lvl_a;
    assign ref_level_out_b = r.lvl_b;
    assign output_mode     = r.mode;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_bit_in;
        ce && busy && cif.sclk_rise && !cif.en_rise && !word_full;
    endsequence

    sequence s_word_done;
        ce && busy && cif.en_rise && word_full;
    endsequence

    sequence s_frame_open;
        ce && !busy && cif.en_fall;
    endsequence

    sequence s_bit_extra;
        ce && busy && cif.sclk_rise && !cif.en_rise && word_full;
    endsequence

    sequence s_word_short;
        ce && busy && cif.en_rise && !word_full;
    endsequence

    sequence s_test_held;
        ce && cif.tmode ##1 ce && cif.tmode;
    endsequence

    sequence s_prog_held;
        ce && !cif.tmode ##1 ce && !cif.tmode && $stable(cif.mode_prog);
    endsequence

    // (RL1) frame start
    a_frame_start: assert property ( // (RL1)
        ce && !busy && cif.en_fall |=> busy && r.cnt == `CDSL_CNT_RST
            && r.word == `CDSL_WORD_RST)
        else $error("enable fall did not open a frame");

    // (RL2) bit count
    a_bit_count: assert property ( // (RL2)
        s_bit_in |=> r.cnt == `CDSL_CNT_W'($past(r.cnt) + 1'b1))
        else $error("bit count did not advance");

    // (RL8) shift order
    a_shift_msb: assert property ( // (RL8)
        s_bit_in |=> r.word == {$past(r.word[`CDSL_WORD_W-2:0]),
                                $past(cif.sdata)})
        else $error("serial bit not shifted in msb first");

    // (RL3) output a load
    a_load_out_a: assert property ( // (RL3)
        s_word_done ##0 !sel_is_b(r.word) |=>
            ref_level_out_a == $past(r.word[`CDSL_CODE_MSB:0])
            && $stable(ref_level_out_b))
        else $error("select 0 did not load output a");

    // (RL3) output b load
    a_load_out_b: assert property ( // (RL3)
        s_word_done ##0 sel_is_b(r.word) |=>
            ref_level_out_b == $past(r.word[`CDSL_CODE_MSB:0])
            && $stable(ref_level_out_a))
        else $error("select 1 did not load output b");

    // (RL4) levels hold
    a_levels_hold: assert property ( // (RL4)
        !(ce && busy && cif.en_rise) |=>
            $stable(ref_level_out_a) && $stable(ref_level_out_b))
        else $error("level changed away from enable rise");

    // (RL5) idle ignore
    a_idle_ignore: assert property ( // (RL5)
        ce && !busy && !cif.en_fall ##1 !busy |->
            $stable(r.word) && $stable(r.cnt))
        else $error("serial activity taken while enable high");

    // (RL7) test force
    a_test_force: assert property ( // (RL7)
        ce && cif.tmode |=> output_mode == `CDSL_MODE_NORMAL)
        else $error("test mode did not force normal output mode");

    // (RL6) programmed mode
    a_mode_prog: assert property ( // (RL6)
        ce && !cif.tmode |=> output_mode == $past(cif.mode_prog))
        else $error("output mode does not follow programmed function");

    // (RL2) word bound
    a_word_bound: assert property ( // (RL2)
        r.cnt <= `CDSL_WORD_BITS)
        else $error("more than one word held");

    // (RL4) short word dropped
    a_short_drop: assert property ( // (RL4)
        ce && busy && cif.en_rise && !word_full |=>
            r.short_frame && $stable(ref_level_out_a)
            && $stable(ref_level_out_b))
        else $error("short word changed a level");

    // (RL1) open keeps levels
    a_open_levels: assert property ( // (RL1)
        s_frame_open |=> $stable(ref_level_out_a) && $stable(ref_level_out_b))
        else $error("frame start changed a level");

    // (RL1) frame only on fall
    a_open_on_fall: assert property ( // (RL1)
        !busy ##1 busy |-> $past(cif.en_fall))
        else $error("frame opened without an enable fall");

    // (RL4) frame closes
    a_frame_close: assert property ( // (RL4)
        ce && busy && cif.en_rise |=> !busy)
        else $error("enable rise did not close the frame");

    // (RL2) extra bits ignored
    a_extra_bits: assert property ( // (RL2)
        s_bit_extra |=> $stable(r.word) && $stable(r.cnt))
        else $error("bit taken beyond a whole word");

    // (RL4) good word counted
    a_good_count: assert property ( // (RL4)
        s_word_done |=> !r.short_frame
            && r.frames == `CDSL_CODE_W'($past(r.frames) + 1'b1))
        else $error("whole word not counted");

    // (RL4) short word closes
    a_short_idle: assert property ( // (RL4)
        s_word_short |=> !busy && $stable(r.word) && $stable(r.cnt))
        else $error("short word left the frame open");

    // (RL3) one output per word
    a_one_output: assert property ( // (RL3)
        s_word_done |=> $stable(ref_level_out_a) || $stable(ref_level_out_b))
        else $error("one word changed both levels");

    // (RL5) idle levels hold
    a_idle_levels: assert property ( // (RL5)
        ce && !busy |=> $stable(ref_level_out_a) && $stable(ref_level_out_b))
        else $error("level changed while enable high");

    // (RL7) test holds normal
    a_test_hold: assert property ( // (RL7)
        s_test_held |=> $stable(output_mode)
            && output_mode == `CDSL_MODE_NORMAL)
        else $error("output mode left normal under test");

    // (RL6) programmed mode holds
    a_prog_hold: assert property ( // (RL6)
        s_prog_held |=> $stable(output_mode))
        else $error("output mode moved with no new function");

endmodule : cdsl_loader

`default_nettype wire

// [include/cdsl_defines.svh]
// Purpose: constants of the reference level serial loader
// Assumes: included by the package and the design files
// Notes: offsets are byte addresses on the register bus
`ifndef CDSL_DEFINES_SVH
`define CDSL_DEFINES_SVH

// serial word layout
`define CDSL_WORD_BITS   4'hc
`define CDSL_CNT_W       4
`define CDSL_WORD_W      12
`define CDSL_CODE_W      8
`define CDSL_SEL_BIT     11
`define CDSL_CODE_MSB    7
`define CDSL_CNT_RST     4'h0
`define CDSL_WORD_RST    12'h000
`define CDSL_LEVEL_RST   8'h00
`define CDSL_FRAMES_RST  8'h00

// output mode
`define CDSL_MODE_W      2
`define CDSL_MODE_NORMAL 2'h0
`define CDSL_MODE_RST    2'h0

// pin vector: sclk, sdata, enable_n, test
`define CDSL_PIN_W       4
`define CDSL_PIN_SCLK    0
`define CDSL_PIN_SDATA   1
`define CDSL_PIN_EN_N    2
`define CDSL_PIN_TEST    3
`define CDSL_PIN_RST     4'h4

// register map
`define CDSL_ADDR_W      8
`define CDSL_REG_CTRL    8'h00
`define CDSL_REG_STATUS  8'h04
`define CDSL_REG_LEVELS  8'h08
`define CDSL_DATA_RST    32'h0000_0000
`define CDSL_HTRANS_NSEQ 1

`endif

// [include/cdsl_pkg.sv]
// Purpose: types of the reference level serial loader
// Assumes: cdsl_defines.svh on the include path
// Notes: each module keeps all its state in one struct
`include "cdsl_defines.svh"

package cdsl_pkg;

    typedef enum logic {
        CDSL_IDLE,
        CDSL_SHIFT
    } cdsl_state_type;

    typedef struct packed {
        cdsl_state_type               state;
        logic [`CDSL_CNT_W-1:0]       cnt;
        logic [`CDSL_WORD_W-1:0]      word;
        logic [`CDSL_CODE_W-1:0]      lvl_a;
        logic [`CDSL_CODE_W-1:0]      lvl_b;
        logic [`CDSL_MODE_W-1:0]      mode;
        logic                         short_frame;
        logic [`CDSL_CODE_W-1:0]      frames;
    } cdsl_core_type;

    typedef struct packed {
        logic [`CDSL_PIN_W-1:0] s1;
        logic [`CDSL_PIN_W-1:0] s2;
        logic [`CDSL_PIN_W-1:0] s3;
    } cdsl_sync_type;

    typedef struct packed {
        logic                     sel;
        logic                     wr;
        logic [`CDSL_ADDR_W-1:0]  addr;
        logic [`CDSL_MODE_W-1:0]  mode_prog;
        logic [31:0]              rdata;
    } cdsl_ahb_type;

endpackage : cdsl_pkg

// [include/cdsl_core_if.sv]
// Purpose: carries pin events and register fields inside the loader
// Assumes: one instance inside cdsl_loader
// Notes: events are single-cycle pulses on hclk
`timescale 1ns/1ns
`default_nettype none
`include "cdsl_defines.svh"

interface cdsl_core_if;
    logic                     sclk_rise;
    logic                     en_fall;
    logic                     en_rise;
    logic                     sdata;
    logic                     tmode;
    logic [`CDSL_MODE_W-1:0]  mode_prog;
    logic [31:0]              status;
    logic [31:0]              levels;

    modport sync (output sclk_rise, output en_fall, output en_rise,
                  output sdata, output tmode);
    modport regs (output mode_prog, input status, input levels);
    modport core (input sclk_rise, input en_fall, input en_rise,
                  input sdata, input tmode, input mode_prog,
                  output status, output levels);
endinterface : cdsl_core_if

`default_nettype wire

// [rtl/cdsl_pin_sync.sv]
// Purpose: two-flop synchronisers and edge detect for the serial pins
// Assumes: pins are asynchronous to hclk, link clock far slower
// Notes: s1 feeds only s2; edges compare s2 with s3
`timescale 1ns/1ns
`default_nettype none
`include "cdsl_defines.svh"

module cdsl_pin_sync (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ce,
    input  wire logic [`CDSL_PIN_W-1:0] pins,
    cdsl_core_if.sync                   ev
);
    cdsl_pkg::cdsl_sync_type r;
    cdsl_pkg::cdsl_sync_type r_nxt;

    always_comb begin
        r_nxt = r;
        if (ce) begin
            r_nxt.s1 = pins;
            r_nxt.s2 = r.s1;
            r_nxt.s3 = r.s2;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{s1: `CDSL_PIN_RST, s2: `CDSL_PIN_RST, s3: `CDSL_PIN_RST};
        end else begin
            r <= r_nxt;
        end
    end

    assign ev.sclk_rise = ce & r.s2[`CDSL_PIN_SCLK] & ~r.s3[`CDSL_PIN_SCLK];
    assign ev.en_fall   = ce & ~r.s2[`CDSL_PIN_EN_N] & r.s3[`CDSL_PIN_EN_N];
    assign ev.en_rise   = ce & r.s2[`CDSL_PIN_EN_N] & ~r.s3[`CDSL_PIN_EN_N];
    // data delayed as much as the clock, so setup and hold carry over
    assign ev.sdata     = r.s2[`CDSL_PIN_SDATA];
    assign ev.tmode     = r.s2[`CDSL_PIN_TEST];

endmodule : cdsl_pin_sync

`default_nettype wire

// [rtl/cdsl_ahb_regs.sv]
// Purpose: AHB-Lite slave holding the control and status registers
// Assumes: single word transfers, one slave on the bus
// Notes: zero wait states while ce is high; read data is caught
//        at the address phase
`timescale 1ns/1ns
`default_nettype none
`include "cdsl_defines.svh"

module cdsl_ahb_regs (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ce,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    cdsl_core_if.regs                   rif
);
    cdsl_pkg::cdsl_ahb_type r;
    cdsl_pkg::cdsl_ahb_type r_nxt;
    logic                   accept;

    // unmapped offsets read as zero, writes there are dropped
    function automatic logic [31:0] read_val(input logic [`CDSL_ADDR_W-1:0] a,
                                             input logic [`CDSL_MODE_W-1:0] m);
        logic [31:0] v;
        v = `CDSL_DATA_RST;
        if (a == `CDSL_REG_CTRL) begin
            v[`CDSL_MODE_W-1:0] = m;
        end else if (a == `CDSL_REG_STATUS) begin
            v = rif.status;
        end else if (a == `CDSL_REG_LEVELS) begin
            v = rif.levels;
        end
        return v;
    endfunction : read_val

    assign accept = ce & hsel & hready & htrans[`CDSL_HTRANS_NSEQ];

    always_comb begin
        r_nxt = r;
        if (ce) begin
            if (r.sel && r.wr && r.addr == `CDSL_REG_CTRL) begin
                r_nxt.mode_prog = hwdata[`CDSL_MODE_W-1:0];
            end
            r_nxt.sel = accept;
            if (accept) begin
                r_nxt.wr    = hwrite;
                r_nxt.addr  = haddr[`CDSL_ADDR_W-1:0];
                r_nxt.rdata = hwrite ? `CDSL_DATA_RST
                                     : read_val(haddr[`CDSL_ADDR_W-1:0], r.mode_prog);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{sel: 1'b0, wr: 1'b0, addr: `CDSL_REG_CTRL,
                   mode_prog: `CDSL_MODE_RST, rdata: `CDSL_DATA_RST};
        end else begin
            r <= r_nxt;
        end
    end

    // hsize is always a word here; nothing narrower is decoded
    assign hrdata        = r.rdata;
    assign hreadyout     = ce;
    assign hresp         = 1'b0;
    assign rif.mode_prog = r.mode_prog;

endmodule : cdsl_ahb_regs

`default_nettype wire

// [bench/cdsl_host_model.sv]
// Purpose: host side driving the reference level serial pins
// Assumes: link clock period 125 ns, unrelated in phase to hclk
// Notes: clock rests low between frames; idle data shows the inverse bit
`timescale 1ns/1ns
`default_nettype none

module cdsl_host_model (
    output var logic sclk,
    output var logic sdata,
    output var logic en_n
);
    initial begin
        sclk  = 1'b0;
        sdata = 1'b1;
        en_n  = 1'b1;
    end

    task automatic open_frame();
        en_n <= 1'b0;
        #63;
    endtask : open_frame

    task automatic shift_word(input logic [11:0] w, input int nbits);
        for (int i = 11; i > 11 - nbits; i--) begin
            sdata <= w[i];
            #62 sclk <= 1'b1;
            #63 sclk <= 1'b0;
        end
        sdata <= ~sdata;
    endtask : shift_word

    task automatic close_frame();
        #62 en_n <= 1'b1;
        #63;
    endtask : close_frame

    // stray clocks with the frame closed or after a whole word, only when a test asks
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sdata <= ~sdata;
            #62 sclk <= 1'b1;
            #63 sclk <= 1'b0;
        end
    endtask : stray_clocks
endmodule : cdsl_host_model

`default_nettype wire

// [bench/control_dac_serial_loader_tb.sv]
// Purpose: self-checking bench of the reference level serial loader
// Assumes: ce held high, one slave on the bus
// Notes: levels expected from the words sent; mode from ctrl and test pin
`timescale 1ns/1ns
`default_nettype none
`include "cdsl_defines.svh"

module control_dac_serial_loader_tb;
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sclk;
    logic        sdata;
    logic        en_n;
    logic        test_mode_force;
    logic [7:0]  lvl_a;
    logic [7:0]  lvl_b;
    logic [1:0]  mode;
    logic [7:0]  exp_a;
    logic [7:0]  exp_b;
    logic [31:0] rd;
    logic [11:0] wrd;
    int          fail_count;
    int          total_checks;

    cdsl_loader uut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ref_dac_serial_clk(sclk), .ref_dac_serial_in(sdata),
        .ref_dac_load_enable_n(en_n), .test_mode_force(test_mode_force),
        .ref_level_out_a(lvl_a), .ref_level_out_b(lvl_b), .output_mode(mode)
    );

    cdsl_host_model host (.sclk(sclk), .sdata(sdata), .en_n(en_n));

    always #2 hclk = ~hclk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_levels();
        chk_word("levels", {16'h0000, exp_b, exp_a}, {16'h0000, lvl_b, lvl_a});
    endtask : chk_levels

    task automatic chk_mode(input logic [1:0] e);
        chk_word("output mode", {30'h0, e}, {30'h0, mode});
    endtask : chk_mode

    // expected level after a whole word closes
    function automatic void apply_word(input logic [11:0] w);
        if (w[`CDSL_SEL_BIT]) begin
            exp_b = w[7:0];
        end else begin
            exp_a = w[7:0];
        end
    endfunction : apply_word

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rv);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rv = hrdata;
        chk_word("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    task automatic load(input logic [11:0] w, input int nbits);
        host.open_frame();
        host.shift_word(w, nbits);
        repeat (8) @(posedge hclk);
        chk_levels();
        host.close_frame();
        if (nbits == 12) begin
            apply_word(w);
        end
        repeat (8) @(posedge hclk);
        chk_levels();
    endtask : load

    initial begin
        logic [11:0] corner [5];
        corner = '{12'h7a5, 12'h85a, 12'h001, 12'hf80, 12'h8ff};
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        test_mode_force = 1'b0;
        exp_a = 8'h00;
        exp_b = 8'h00;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(32'ha0f3e396));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_levels();
        chk_mode(2'h0);
        $display("test reset done");
        foreach (corner[i]) begin
            load(corner[i], 12);
        end
        $display("test corner words done");
        for (int i = 0; i < 16; i++) begin
            load(12'($urandom), 12);
        end
        $display("test random words done");
        load(12'($urandom), 8);
        ahb(1'b0, `CDSL_REG_STATUS, 32'h0, rd);
        chk_word("status", 32'h0015_0030, rd);
        $display("test short word done");
        host.stray_clocks(6);
        repeat (8) @(posedge hclk);
        chk_levels();
        load({1'b1, 11'($urandom)}, 12);
        $display("test closed frame done");
        wrd = 12'($urandom);
        host.open_frame();
        host.shift_word(wrd, 12);
        host.stray_clocks(3);
        host.close_frame();
        apply_word(wrd);
        repeat (8) @(posedge hclk);
        chk_levels();
        $display("test extra bits done");
        ahb(1'b0, `CDSL_REG_LEVELS, 32'h0, rd);
        chk_word("levels register", {16'h0000, exp_b, exp_a}, rd);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge hclk);
                test_mode_force <= t[0];
                ahb(1'b1, `CDSL_REG_CTRL, {30'h0, m[1:0]}, rd);
                repeat (6) @(posedge hclk);
                chk_mode(t[0] ? `CDSL_MODE_NORMAL : m[1:0]);
                ahb(1'b0, `CDSL_REG_CTRL, 32'h0, rd);
                chk_word("ctrl", {30'h0, m[1:0]}, rd);
            end
        end
        @(posedge hclk);
        test_mode_force <= 1'b0;
        repeat (6) @(posedge hclk);
        chk_mode(2'h3);
        $display("test mode select done");
        ahb(1'b1, 32'h0000_000c, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h0000_000c, 32'h0, rd);
        chk_word("unmapped", 32'h0000_0000, rd);
        ahb(1'b0, `CDSL_REG_CTRL, 32'h0, rd);
        chk_word("ctrl kept", 32'h0000_0003, rd);
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule : control_dac_serial_loader_tb

`default_nettype wire
